// ==== pkg/timer_ccp_pkg.sv ====
// Constants, field layouts and carrier types for the gated timer with capture/compare.
// Summary of operation
// [R1] Prescaler divides count clock by 1, 2, 4, 8.
// [R2] Prescaler hidden; cleared by any count byte write.
// [R3] Sync bypass skips external clock alignment stage.
// [R4] Async external counting continues during sleep; overflow wakes.
// [R5] Sync/async switch may drop or add one.
// [R6] Count byte reads always return a stable value.
// [R7] Software must allow for low-to-high byte carry.
// [R8] Software stops counter before writing count bytes.
// [R9] Gate enable and gate polarity select gating.
// [R10] Active gate lets counter advance on clock edges.
// [R11] Inactive gate holds count; polarity picks level.
// [R12] Mode zero switches off and resets unit.
// [R13] Modes 0100/0101 capture on falling/rising pin edges.
// [R14] Mode 1000: pin low, match drives high, flag.
// [R15] Mode 1001: pin high, match drives low, flag.
// [R16] Mode 1010: match flags only; pin released.
// [R17] PWM duty is duty_high_byte over duty_low_bits.
// [R18] Event flag set on capture/match; software clears. A mode 0010 match does not set it.
// [R19] Capture copies full count with flag set.
// [R20] Compare match when count equals compare pair.
package timer_ccp_pkg;
	localparam logic [7:0] TCON_OFS   = 8'h00;
	localparam logic [7:0] CNTL_OFS   = 8'h04;
	localparam logic [7:0] CNTH_OFS   = 8'h08;
	localparam logic [7:0] GCON_OFS   = 8'h0c;
	localparam logic [7:0] CCPCON_OFS = 8'h10;
	localparam logic [7:0] DUTYH_OFS  = 8'h14;
	localparam logic [7:0] CCPH_OFS   = 8'h18;
	localparam logic [7:0] STAT_OFS   = 8'h1c;
	localparam logic [7:0] REG_RST    = 8'h00;
	localparam logic [15:0] CNT_RST   = 16'h0000;
	localparam int TON_BIT   = 0;
	localparam int EXT_BIT   = 1;
	localparam int BYP_BIT   = 2;
	localparam int PS_LSB    = 4;
	localparam int GLVL_BIT  = 0;
	localparam int GPOL_BIT  = 6;
	localparam int GEN_BIT   = 7;
	localparam int DUTY_LSB  = 4;
	localparam int FLAG_BIT  = 0;
	localparam int OVF_BIT   = 1;
	localparam int PWM_W     = 10;
	localparam logic [3:0] MODE_OFF   = 4'h0;
	localparam logic [3:0] MODE_TOG   = 4'h2;
	localparam logic [3:0] CAP_FALL   = 4'h4;
	localparam logic [3:0] CAP_RISE   = 4'h5;
	localparam logic [3:0] CAP_RISE4  = 4'h6;
	localparam logic [3:0] CAP_RISE16 = 4'h7;
	localparam logic [3:0] CMP_SET    = 4'h8;
	localparam logic [3:0] CMP_CLR    = 4'h9;
	localparam logic [3:0] CMP_SOFT   = 4'ha;
	localparam logic [3:0] CMP_TRIG   = 4'hb;
	localparam logic [3:0] CAP4_LAST  = 4'h3;
	localparam logic [3:0] CAP16_LAST = 4'hf;

	typedef struct packed {
		logic [1:0] prescale_select;
		logic       sync_bypass;
		logic       ext_clock;
		logic       timer_on;
	} timer_ctrl_t;

	typedef struct packed {
		logic gate_enable_bit;
		logic gate_polarity;
	} gate_ctrl_t;
endpackage : timer_ccp_pkg

// ==== core/pin_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	initial begin
		if (WIDTH < 1) begin
			$error("pin_sync needs at least one bit");
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule : pin_sync

// ==== core/count_prescaler.sv ====
// Hidden prescale counter giving one increment per 1, 2, 4 or 8 source ticks.
`timescale 1ns/1ps
module count_prescaler #(
	parameter int WIDTH = 3
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_clear,
	input  wire logic       i_tick,
	input  wire logic [1:0] i_select,
	output logic            o_inc
);
	logic [WIDTH-1:0] div_reg;
	logic [WIDTH-1:0] div_next;
	logic [WIDTH-1:0] mask;

	initial begin
		if (WIDTH < 3) begin
			$error("count_prescaler needs three bits for divide by eight");
		end
	end

	always_comb begin
		mask  = WIDTH'((1 << i_select) - 1); // R1
		o_inc = i_tick && ((div_reg & mask) == mask);
		div_next = div_reg;
		if (i_clear) begin
			div_next = '0; // R2
		end else if (i_tick) begin
			div_next = o_inc ? '0 : div_reg + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end
endmodule : count_prescaler

// ==== core/gated_timer_ccp.sv ====
// Gated 16-bit timer with capture/compare/PWM unit and an APB register slave.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module gated_timer_ccp (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_count_clock,
	input  wire logic        i_gate_input,
	input  wire logic        i_sleep,
	input  wire logic        i_ccp_pin,
	output logic             o_ccp_pin_out,
	output logic             o_ccp_pin_oe,
	output logic             o_ccp_event_flag,
	output logic             o_overflow_flag,
	output logic             o_wake
);
	localparam int PWM_DUTY_W = timer_ccp_pkg::PWM_W;

	timer_ccp_pkg::timer_ctrl_t tctrl_reg;
	timer_ccp_pkg::timer_ctrl_t tctrl_next;
	timer_ccp_pkg::gate_ctrl_t  gctrl_reg;
	timer_ccp_pkg::gate_ctrl_t  gctrl_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [3:0]  mode_reg;
	logic [3:0]  mode_next;
	logic [1:0]  duty_low_reg;
	logic [1:0]  duty_low_next;
	logic [7:0]  value_low_reg;
	logic [7:0]  value_low_next;
	logic [7:0]  value_high_reg;
	logic [7:0]  value_high_next;
	logic [3:0]  cap_cnt_reg;
	logic [3:0]  cap_cnt_next;
	logic        pin_reg;
	logic        pin_next;
	logic        flag_reg;
	logic        flag_next;
	logic        ovf_reg;
	logic        ovf_next;
	logic        match_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [2:0]  pins_sync;
	logic        clk_d3_reg;
	logic        clk_d4_reg;
	logic        cap_d3_reg;
	logic        clk_s;
	logic        gate_s;
	logic        cap_s;
	logic        ext_edge;
	logic        src_tick;
	logic        gate_ok;
	logic        run;
	logic        inc;
	logic        wr;
	logic        hit;
	logic        wr_cntl;
	logic        wr_cnth;
	logic        wr_mode;
	logic        cap_rise;
	logic        cap_fall;
	logic        cap_hit;
	logic        match;
	logic        cmp_hit;
	logic        is_compare;
	logic        is_pwm;
	logic [PWM_DUTY_W-1:0] duty;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		addr_is = (a == ofs);
	endfunction : addr_is

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst    (i_rst),
		.i_async  ({i_count_clock, i_gate_input, i_ccp_pin}),
		.o_sync   (pins_sync)
	);

	assign clk_s  = pins_sync[2];
	assign gate_s = pins_sync[1];
	assign cap_s  = pins_sync[0];

	// The bypass path takes the edge one stage earlier; flipping the bypass
	// while an edge is in flight can therefore drop or double one increment.
	assign ext_edge = tctrl_reg.sync_bypass ? (clk_s && !clk_d3_reg) // R3 R5
		: (clk_d3_reg && !clk_d4_reg);
	assign src_tick = tctrl_reg.ext_clock ? ext_edge : 1'b1; // R10

	// Gate passes when disabled, or when the pin matches the chosen polarity.
	assign gate_ok = !gctrl_reg.gate_enable_bit // R9
		|| (gate_s == gctrl_reg.gate_polarity); // R11

	// Only the bypassed external clock keeps the timer going in sleep.
	assign run = tctrl_reg.timer_on && gate_ok && (!i_sleep // R4
		|| (tctrl_reg.ext_clock && tctrl_reg.sync_bypass));

	assign wr      = i_psel && i_penable && i_pwrite;
	assign wr_cntl = wr && addr_is(i_paddr, timer_ccp_pkg::CNTL_OFS);
	assign wr_cnth = wr && addr_is(i_paddr, timer_ccp_pkg::CNTH_OFS);
	assign wr_mode = wr && addr_is(i_paddr, timer_ccp_pkg::CCPCON_OFS);

	count_prescaler #(
		.WIDTH(3)
	) u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_rst    (i_rst),
		.i_clear  (wr_cntl || wr_cnth), // R2
		.i_tick   (run && src_tick),
		.i_select (tctrl_reg.prescale_select), // R1
		.o_inc    (inc)
	);

	always_comb begin
		hit = 1'b0;
		case (i_paddr)
			timer_ccp_pkg::TCON_OFS,
			timer_ccp_pkg::CNTL_OFS,
			timer_ccp_pkg::CNTH_OFS,
			timer_ccp_pkg::GCON_OFS,
			timer_ccp_pkg::CCPCON_OFS,
			timer_ccp_pkg::DUTYH_OFS,
			timer_ccp_pkg::CCPH_OFS,
			timer_ccp_pkg::STAT_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit;

	// Read data is caught in the setup cycle, so each count byte is registered
	// from count_reg at its own read; a carry between the two reads can split them.
	always_comb begin
		rdata_next = rdata_reg;
		if (i_psel && !i_penable) begin
			rdata_next = 32'h0000_0000;
			case (i_paddr)
				timer_ccp_pkg::TCON_OFS: begin
					rdata_next[timer_ccp_pkg::TON_BIT] = tctrl_reg.timer_on;
					rdata_next[timer_ccp_pkg::EXT_BIT] = tctrl_reg.ext_clock;
					rdata_next[timer_ccp_pkg::BYP_BIT] = tctrl_reg.sync_bypass;
					rdata_next[timer_ccp_pkg::PS_LSB +: 2] = tctrl_reg.prescale_select;
				end
				timer_ccp_pkg::CNTL_OFS: rdata_next[7:0] = count_reg[7:0]; // R6
				timer_ccp_pkg::CNTH_OFS: rdata_next[7:0] = count_reg[15:8]; // R6
				timer_ccp_pkg::GCON_OFS: begin
					rdata_next[timer_ccp_pkg::GEN_BIT]  = gctrl_reg.gate_enable_bit;
					rdata_next[timer_ccp_pkg::GPOL_BIT] = gctrl_reg.gate_polarity;
					rdata_next[timer_ccp_pkg::GLVL_BIT] = gate_s;
				end
				timer_ccp_pkg::CCPCON_OFS: begin
					rdata_next[3:0] = mode_reg;
					rdata_next[timer_ccp_pkg::DUTY_LSB +: 2] = duty_low_reg;
				end
				timer_ccp_pkg::DUTYH_OFS: rdata_next[7:0] = value_low_reg;
				timer_ccp_pkg::CCPH_OFS:  rdata_next[7:0] = value_high_reg;
				timer_ccp_pkg::STAT_OFS: begin
					rdata_next[timer_ccp_pkg::FLAG_BIT] = flag_reg;
					rdata_next[timer_ccp_pkg::OVF_BIT]  = ovf_reg;
				end
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		tctrl_next = tctrl_reg;
		gctrl_next = gctrl_reg;
		if (wr && addr_is(i_paddr, timer_ccp_pkg::TCON_OFS)) begin
			tctrl_next.timer_on        = i_pwdata[timer_ccp_pkg::TON_BIT];
			tctrl_next.ext_clock       = i_pwdata[timer_ccp_pkg::EXT_BIT];
			tctrl_next.sync_bypass     = i_pwdata[timer_ccp_pkg::BYP_BIT];
			tctrl_next.prescale_select = i_pwdata[timer_ccp_pkg::PS_LSB +: 2];
		end
		if (wr && addr_is(i_paddr, timer_ccp_pkg::GCON_OFS)) begin
			gctrl_next.gate_enable_bit = i_pwdata[timer_ccp_pkg::GEN_BIT];
			gctrl_next.gate_polarity   = i_pwdata[timer_ccp_pkg::GPOL_BIT];
		end
	end

	assign is_compare = (mode_reg == timer_ccp_pkg::MODE_TOG)
		|| (mode_reg[3:2] == 2'b10);
	assign is_pwm     = (mode_reg[3:2] == 2'b11);
	assign match      = ({value_high_reg, value_low_reg} == count_reg); // R20
	assign cmp_hit    = is_compare && match && !match_reg;

	// A software write to a count byte wins over a same-cycle increment;
	// a write racing a running counter is the user's hazard to avoid.
	always_comb begin
		count_next = count_reg;
		ovf_next   = ovf_reg;
		if (wr && addr_is(i_paddr, timer_ccp_pkg::STAT_OFS)
			&& i_pwdata[timer_ccp_pkg::OVF_BIT]) begin
			ovf_next = 1'b0;
		end
		if (wr_cntl || wr_cnth) begin // R8
			if (wr_cntl) begin
				count_next[7:0] = i_pwdata[7:0];
			end
			if (wr_cnth) begin
				count_next[15:8] = i_pwdata[7:0];
			end
		end else if (cmp_hit && (mode_reg == timer_ccp_pkg::CMP_TRIG)) begin
			count_next = timer_ccp_pkg::CNT_RST;
		end else if (inc) begin // R10 R11
			count_next = count_reg + 16'h0001;
			if (count_reg == 16'hffff) begin
				ovf_next = 1'b1; // R4
			end
		end
	end

	assign cap_rise = cap_s && !cap_d3_reg;
	assign cap_fall = !cap_s && cap_d3_reg;

	always_comb begin
		cap_hit = 1'b0;
		unique case (mode_reg)
			timer_ccp_pkg::CAP_FALL:   cap_hit = cap_fall; // R13
			timer_ccp_pkg::CAP_RISE:   cap_hit = cap_rise; // R13
			timer_ccp_pkg::CAP_RISE4:
				cap_hit = cap_rise && (cap_cnt_reg[1:0] == timer_ccp_pkg::CAP4_LAST[1:0]);
			timer_ccp_pkg::CAP_RISE16:
				cap_hit = cap_rise && (cap_cnt_reg == timer_ccp_pkg::CAP16_LAST);
			default: cap_hit = 1'b0;
		endcase
	end

	assign duty = {value_low_reg, duty_low_reg}; // R17

	always_comb begin
		mode_next       = mode_reg;
		duty_low_next   = duty_low_reg;
		value_low_next  = value_low_reg;
		value_high_next = value_high_reg;
		cap_cnt_next    = cap_cnt_reg;
		pin_next        = pin_reg;
		flag_next       = flag_reg;
		if (wr && addr_is(i_paddr, timer_ccp_pkg::DUTYH_OFS)) begin
			value_low_next = i_pwdata[7:0];
		end
		if (wr && addr_is(i_paddr, timer_ccp_pkg::CCPH_OFS)) begin
			value_high_next = i_pwdata[7:0];
		end
		if (cap_rise && (mode_reg == timer_ccp_pkg::CAP_RISE4
			|| mode_reg == timer_ccp_pkg::CAP_RISE16)) begin
			cap_cnt_next = cap_cnt_reg + 4'h1;
		end
		if (cap_hit) begin
			value_low_next  = count_reg[7:0]; // R19
			value_high_next = count_reg[15:8]; // R19
		end
		if (cmp_hit) begin
			unique case (mode_reg)
				timer_ccp_pkg::MODE_TOG: pin_next = !pin_reg;
				timer_ccp_pkg::CMP_SET:  pin_next = 1'b1; // R14
				timer_ccp_pkg::CMP_CLR:  pin_next = 1'b0; // R15
				default:                 pin_next = pin_reg; // R16
			endcase
		end
		if (is_pwm) begin
			pin_next = (count_reg[PWM_DUTY_W-1:0] < duty); // R17
		end
		if (wr_mode) begin
			mode_next     = i_pwdata[3:0];
			duty_low_next = i_pwdata[timer_ccp_pkg::DUTY_LSB +: 2];
			cap_cnt_next  = 4'h0;
			if (i_pwdata[3:0] == timer_ccp_pkg::CMP_SET) begin
				pin_next = 1'b0; // R14
			end else if (i_pwdata[3:0] == timer_ccp_pkg::CMP_CLR) begin
				pin_next = 1'b1; // R15
			end else if (i_pwdata[3:0] == timer_ccp_pkg::MODE_OFF) begin
				pin_next = 1'b0; // R12
			end
		end
		if (mode_reg == timer_ccp_pkg::MODE_OFF && !wr_mode) begin
			pin_next     = 1'b0; // R12
			cap_cnt_next = 4'h0; // R12
		end
		// A capture, or a match outside mode 0010, in the clearing cycle keeps the flag set.
		if (wr && addr_is(i_paddr, timer_ccp_pkg::STAT_OFS)
			&& i_pwdata[timer_ccp_pkg::FLAG_BIT]) begin
			flag_next = 1'b0; // R18
		end
		if (cap_hit || (cmp_hit && mode_reg != timer_ccp_pkg::MODE_TOG)) begin
			flag_next = 1'b1; // R18
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tctrl_reg      <= '0;
			gctrl_reg      <= '0;
			count_reg      <= timer_ccp_pkg::CNT_RST;
			ovf_reg        <= 1'b0;
			rdata_reg      <= 32'h0000_0000;
			clk_d3_reg     <= 1'b0;
			clk_d4_reg     <= 1'b0;
			cap_d3_reg     <= 1'b0;
			match_reg      <= 1'b0;
		end else begin
			tctrl_reg      <= tctrl_next;
			gctrl_reg      <= gctrl_next;
			count_reg      <= count_next;
			ovf_reg        <= ovf_next;
			rdata_reg      <= rdata_next;
			clk_d3_reg     <= clk_s;
			clk_d4_reg     <= clk_d3_reg;
			cap_d3_reg     <= cap_s;
			match_reg      <= match;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode_reg       <= timer_ccp_pkg::MODE_OFF;
			duty_low_reg   <= 2'h0;
			value_low_reg  <= timer_ccp_pkg::REG_RST;
			value_high_reg <= timer_ccp_pkg::REG_RST;
			cap_cnt_reg    <= 4'h0;
			pin_reg        <= 1'b0;
			flag_reg       <= 1'b0;
		end else begin
			mode_reg       <= mode_next;
			duty_low_reg   <= duty_low_next;
			value_low_reg  <= value_low_next;
			value_high_reg <= value_high_next;
			cap_cnt_reg    <= cap_cnt_next;
			pin_reg        <= pin_next;
			flag_reg       <= flag_next;
		end
	end

	assign o_prdata         = rdata_reg;
	assign o_ccp_pin_out    = pin_reg;
	assign o_ccp_pin_oe     = is_compare && (mode_reg != timer_ccp_pkg::CMP_SOFT) // R16
		&& (mode_reg != timer_ccp_pkg::CMP_TRIG) || is_pwm;
	assign o_ccp_event_flag = flag_reg;
	assign o_overflow_flag  = ovf_reg;
	assign o_wake           = ovf_reg && i_sleep; // R4
endmodule : gated_timer_ccp

// ==== testbench/timer_ccp_chk.sv ====
// Checker for bus, pin and flag behaviour at the timer top ports.
`timescale 1ns/1ps
module timer_ccp_chk (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pready,
	input  wire logic        o_pslverr,
	input  wire logic        i_sleep,
	input  wire logic        o_ccp_pin_out,
	input  wire logic        o_ccp_pin_oe,
	input  wire logic        o_ccp_event_flag,
	input  wire logic        o_overflow_flag,
	input  wire logic        o_wake
);
	logic       acc;
	logic       wr_ccp;
	logic [3:0] mode_reg;
	logic [3:0] mode_next;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	assign acc    = i_psel && i_penable;
	assign wr_ccp = acc && i_pwrite && i_paddr == timer_ccp_pkg::CCPCON_OFS;
	// A shadow of the mode field lets the pin enable be judged from bus traffic alone.
	always_comb begin
		mode_next = wr_ccp ? i_pwdata[3:0] : mode_reg;
	end
	always_ff @(posedge i_ref_clk) begin
		mode_reg <= i_rst ? 4'h0 : mode_next;
	end
	chk_ready_high: assert property (o_pready)
		else $error("pready low");
	chk_err_unmapped: assert property (acc && (i_paddr > timer_ccp_pkg::STAT_OFS
		|| i_paddr[1:0] != 2'h0) |-> o_pslverr) else $error("no slave error");
	chk_err_data: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
		else $error("error read data not zero");
	chk_mapped_ok: assert property (acc && i_paddr <= timer_ccp_pkg::STAT_OFS
		&& i_paddr[1:0] == 2'h0 |-> !o_pslverr) else $error("spurious slave error");
	chk_wake_level: assert property (o_wake == (o_overflow_flag && i_sleep))
		else $error("wake mismatch");
	chk_flag_sticky: assert property (o_ccp_event_flag && !(acc && i_pwrite)
		|=> o_ccp_event_flag) else $error("event flag lost");
	chk_ovf_sticky: assert property (o_overflow_flag && !(acc && i_pwrite)
		|=> o_overflow_flag) else $error("overflow flag lost");
	chk_oe_mode: assert property (o_ccp_pin_oe == (mode_reg inside {4'h2, 4'h8, 4'h9}
		|| mode_reg[3:2] == 2'h3)) else $error("pin enable mismatch");
	chk_off_pin: assert property (mode_reg == 4'h0 && $past(mode_reg) == 4'h0
		|-> !o_ccp_pin_out) else $error("pin driven while off");
	chk_setup_low: assert property (wr_ccp && i_pwdata[3:0] == timer_ccp_pkg::CMP_SET
		|=> ##[0:1] !o_ccp_pin_out) else $error("pin not low at setup");
	chk_setup_high: assert property (wr_ccp && i_pwdata[3:0] == timer_ccp_pkg::CMP_CLR
		|=> ##[0:1] o_ccp_pin_out) else $error("pin not high at setup");
	cover property ($rose(o_ccp_event_flag));
	cover property ($rose(o_overflow_flag));
	cover property (o_pslverr);
endmodule : timer_ccp_chk

bind gated_timer_ccp timer_ccp_chk i_chk (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep),
	.o_ccp_pin_out(o_ccp_pin_out), .o_ccp_pin_oe(o_ccp_pin_oe),
	.o_ccp_event_flag(o_ccp_event_flag), .o_overflow_flag(o_overflow_flag), .o_wake(o_wake)
);

// ==== testbench/timer_pin_partner.sv ====
// Far-side model driving the external count clock, gate and capture pins.
`timescale 1ns/1ps
module timer_pin_partner (
	input  wire logic i_ref_clk,
	output logic      o_count_clock,
	output logic      o_gate_input,
	output logic      o_ccp_pin
);
	initial begin
		o_count_clock = 1'h0;
		o_gate_input  = 1'h0;
		o_ccp_pin     = 1'h0;
	end
	// The clock stands low between bursts; half periods of several cycles let the
	// synchroniser see every level, small ones model a fast source.
	task automatic pulse_clock(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge i_ref_clk);
			o_count_clock <= 1'h1;
			repeat (half) @(posedge i_ref_clk);
			o_count_clock <= 1'h0;
		end
	endtask : pulse_clock
	task automatic set_pins(input logic gate, input logic cap);
		@(posedge i_ref_clk);
		o_gate_input <= gate;
		o_ccp_pin    <= cap;
	endtask : set_pins
endmodule : timer_pin_partner

// ==== testbench/gated_timer_capture_compare_bench.sv ====
// Self-checking bench for the gated timer with capture/compare unit.
`timescale 1ns/1ps
module gated_timer_capture_compare_bench;
	logic        clk     = 1'h0;
	logic        rst     = 1'h1;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        sleep   = 1'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cclk;
	logic        gate;
	logic        cap;
	logic        pin_out;
	logic        oe;
	logic        flag;
	logic        ovf;
	logic        wake;
	logic [31:0] rdat;
	logic        rerr;
	int          fail_count = 0;
	int          cmp_count  = 0;

	always #25 clk = ~clk;
	gated_timer_ccp i_dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_count_clock(cclk), .i_gate_input(gate),
		.i_sleep(sleep), .i_ccp_pin(cap), .o_ccp_pin_out(pin_out), .o_ccp_pin_oe(oe),
		.o_ccp_event_flag(flag), .o_overflow_flag(ovf), .o_wake(wake));
	timer_pin_partner i_far (.i_ref_clk(clk), .o_count_clock(cclk), .o_gate_input(gate),
		.o_ccp_pin(cap));

	task automatic results();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		check({31'h0, pready}, 32'h1);
		if (pready !== 1'h1) results();
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		check(rdat, e);
	endtask : rd
	// Count bytes are only touched with the timer stopped, so no carry can split them.
	task automatic setcnt(input logic [15:0] v);
		wr(timer_ccp_pkg::CNTL_OFS, {24'h0, v[7:0]});
		wr(timer_ccp_pkg::CNTH_OFS, {24'h0, v[15:8]});
	endtask : setcnt
	task automatic getcnt(output int c);
		apb(1'h0, timer_ccp_pkg::CNTL_OFS, 32'h0);
		c = int'(rdat[7:0]);
		apb(1'h0, timer_ccp_pkg::CNTH_OFS, 32'h0);
		c = c | (int'(rdat[7:0]) << 8);
	endtask : getcnt
	// Start and stop edges lie 67 cycles apart; one count of slack covers pipeline phase.
	task automatic run_cnt(input logic [31:0] tcon, input int e);
		int c;
		setcnt(16'h0000);
		wr(timer_ccp_pkg::TCON_OFS, tcon);
		repeat (64) @(posedge clk);
		wr(timer_ccp_pkg::TCON_OFS, 32'h0);
		getcnt(c);
		check((c >= e - 1 && c <= e + 1) ? e : c, e);
	endtask : run_cnt
	task automatic wait_ev(input logic o, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((o ? ovf : flag) !== 1'h1 && n < lim);
		check({31'h0, o ? ovf : flag}, 32'h1);
		if ((o ? ovf : flag) !== 1'h1) results();
	endtask : wait_ev

	initial begin
		int p;
		int v;
		int got;
		v = $urandom(32'h3cba);
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		for (p = 0; p < 8; p++) begin
			rd(8'(p * 4), 32'h0);
		end
		rd(8'h20, 32'h0);
		check({31'h0, rerr}, 32'h1);
		v = $urandom;
		wr(timer_ccp_pkg::GCON_OFS, v);
		rd(timer_ccp_pkg::GCON_OFS, v & 32'hc0);
		wr(timer_ccp_pkg::CCPCON_OFS, v & 32'h30);
		rd(timer_ccp_pkg::CCPCON_OFS, v & 32'h30);
		wr(timer_ccp_pkg::DUTYH_OFS, v);
		rd(timer_ccp_pkg::DUTYH_OFS, v & 32'hff);
		// The random gate setting above could hold the counter, so gating is switched off.
		wr(timer_ccp_pkg::GCON_OFS, 32'h0);
		for (p = 0; p < 4; p++) begin
			run_cnt(32'(p << 4) | 32'h1, 67 >> p);
		end
		for (p = 0; p < 2; p++) begin
			wr(timer_ccp_pkg::GCON_OFS, 32'h80 | 32'(p << 6));
			i_far.set_pins(1'(!p), 1'h0);
			run_cnt(32'h1, 0);
			i_far.set_pins(1'(p), 1'h0);
			run_cnt(32'h1, 67);
		end
		wr(timer_ccp_pkg::GCON_OFS, 32'h0);
		i_far.set_pins(1'h0, 1'h0);
		run_cnt(32'h1, 67);
		for (p = 3; p < 8; p += 4) begin
			setcnt(16'h0000);
			wr(timer_ccp_pkg::TCON_OFS, 32'(p));
			i_far.pulse_clock(5, 3);
			repeat (8) @(posedge clk);
			wr(timer_ccp_pkg::TCON_OFS, 32'h0);
			getcnt(got);
			check(got, 5);
		end
		for (p = 0; p < 2; p++) begin
			v = $urandom & 32'hffff;
			setcnt(16'(v));
			i_far.set_pins(1'h0, 1'(p));
			wr(timer_ccp_pkg::CCPCON_OFS, 32'h4 + 32'(p));
			i_far.set_pins(1'h0, 1'(!p));
			repeat (8) @(negedge clk);
			check({31'h0, flag}, 32'h0);
			i_far.set_pins(1'h0, 1'(p));
			wait_ev(1'h0, 16);
			rd(timer_ccp_pkg::DUTYH_OFS, v & 32'hff);
			rd(timer_ccp_pkg::CCPH_OFS, v >> 8);
			wr(timer_ccp_pkg::STAT_OFS, 32'h1);
			rd(timer_ccp_pkg::STAT_OFS, 32'h0);
			wr(timer_ccp_pkg::CCPCON_OFS, 32'h0);
		end
		for (p = 8; p < 11; p++) begin
			v = ($urandom & 32'hff00) | 32'h80;
			wr(timer_ccp_pkg::DUTYH_OFS, v);
			wr(timer_ccp_pkg::CCPH_OFS, v >> 8);
			setcnt(16'(v - 20));
			wr(timer_ccp_pkg::CCPCON_OFS, 32'(p));
			@(negedge clk);
			check({oe, oe & pin_out}, p == 8 ? 2 : p == 9 ? 3 : 0);
			wr(timer_ccp_pkg::TCON_OFS, 32'h1);
			check({31'h0, flag}, 32'h0);
			wait_ev(1'h0, 40);
			@(negedge clk);
			check({oe, oe & pin_out}, p == 8 ? 3 : p == 9 ? 2 : 0);
			wr(timer_ccp_pkg::TCON_OFS, 32'h0);
			wr(timer_ccp_pkg::STAT_OFS, 32'h1);
			wr(timer_ccp_pkg::CCPCON_OFS, 32'h0);
			@(negedge clk);
			check({oe, pin_out, flag}, 0);
		end
		v = $urandom & 32'h3ff;
		wr(timer_ccp_pkg::DUTYH_OFS, v >> 2);
		wr(timer_ccp_pkg::CCPCON_OFS, 32'hc | ((v & 32'h3) << 4));
		wr(timer_ccp_pkg::TCON_OFS, 32'h1);
		repeat (1030) @(negedge clk);
		got = 0;
		repeat (1024) begin
			@(negedge clk);
			got += int'(pin_out);
		end
		check(got, v);
		wr(timer_ccp_pkg::TCON_OFS, 32'h0);
		wr(timer_ccp_pkg::CCPCON_OFS, 32'h0);
		// The long PWM run may have wrapped the count, so the overflow flag is cleared first.
		wr(timer_ccp_pkg::STAT_OFS, 32'h3);
		rd(timer_ccp_pkg::STAT_OFS, 32'h0);
		sleep <= 1'h1;
		run_cnt(32'h1, 0);
		setcnt(16'hfffe);
		wr(timer_ccp_pkg::TCON_OFS, 32'h7);
		i_far.pulse_clock(3, 5);
		wait_ev(1'h1, 40);
		check({31'h0, wake}, 32'h1);
		wr(timer_ccp_pkg::TCON_OFS, 32'h0);
		sleep <= 1'h0;
		wr(timer_ccp_pkg::STAT_OFS, 32'h2);
		rd(timer_ccp_pkg::STAT_OFS, 32'h0);
		results();
	end
endmodule : gated_timer_capture_compare_bench
